// File: logic/ude_endpoint_engine.sv
/*
  Endpoint protocol engine of a full-speed USB device: bus reset and suspend
  detection, control stages, bulk/interrupt packet handling, per-endpoint
  buffers, receive byte counts, endpoint 1 DMA handshake and power-down.
  Assumes a serial interface engine on ref_clk that decodes tokens and bytes,
  raw D+/D- levels for line state, and a local MCU on the register port.
*/
`timescale 1ns/10ps
// Notes on behaviour
// - SE0 held 2.5 us flags bus reset and interrupts the MCU.
// - idle held 3 ms or longer raises the suspend interrupt.
// - suspend clears itself on the EOP ending resume signalling.
// - endpoint 1 DMA moves one byte or two bytes per unit.
// - demand DMA holds the request until the whole packet is moved.
// - single DMA drops the request after every unit.
// - writing A0h to system control stops the oscillator: power-down.
// - only hardware reset restarts the oscillator; MCU reconfigures after.
// - power-down keeps register access but blocks all fifo access.
// - setup token stores eight bytes in setup registers, then ACK.
// - control write data goes to endpoint 0 receive buffer, then ACK.
// - control read sends preloaded endpoint 0 transmit data on IN.
// - status stage: ZLP for IN after writes, ACK empty OUT after reads.
// - host ACK clears transmit ready and requests the next packet.
// - good OUT packet is stored, ACKed, marked ready, interrupt raised.
// - max packet size per endpoint, capped at 8 or 64 bytes.
// - EOP appended on transmit after IN only, stripped on receive.
// - fewer bytes than max makes a short packet; none makes ZLP.
// - received bytes are counted per endpoint 0, 1 and 2.
// - endpoint 3 is transmit only; direction bits ignore it.
// - interrupt status bits read zero while their enable is clear.
module ude_endpoint_engine #(
  parameter int IdleCyc = ude_pkg::SUSPEND_IDLE_CYC
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic usbDp,
  input wire logic usbDm,
  input wire logic [5:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWe,
  input wire logic regRe,
  output logic [15:0] regRdata,
  input wire logic dmaAcknowledge,
  output logic dmaRequest,
  output logic intRequestOut,
  output logic oscEnable,
  input wire logic uTokValid,
  input wire logic [1:0] uTokPid,
  input wire logic [1:0] uTokEp,
  input wire logic uRxValid,
  input wire logic [7:0] uRxData,
  input wire logic uRxEop,
  input wire logic uRxErr,
  input wire logic uTxReady,
  input wire logic uHostAck,
  output logic uTxValid,
  output logic [7:0] uTxData,
  output logic uTxEop,
  output logic uHsValid,
  output logic uHsAck
);
  localparam logic [9:0] RST_M1 = 10'(ude_pkg::BUS_RESET_CYC - 1);
  localparam logic [19:0] IDLE_M1 = 20'(IdleCyc - 1);

  typedef struct packed {
    logic [1:0] dpS;
    logic [1:0] dmS;
    logic [9:0] se0Cnt;
    logic [19:0] idleCnt;
    logic busRst;
    logic susp;
    logic sawSe0;
    logic pwrDown;
    logic [7:0] intEn;
    logic [1:0] dirTx;
    logic [2:0] dmaCtl;
    logic [4:0][6:0] maxPkt;
    logic [7:0][7:0] setup;
    logic [3:0] setCnt;
    logic [2:0] rxRdy;
    logic [3:0] txRdy;
    logic [2:0][6:0] rxCnt;
    logic [4:0][63:0][7:0] mem;
    logic [4:0][6:0] wp;
    logic [4:0][6:0] rp;
    ude_pkg::ude_state_e st;
    logic [1:0] curEp;
    logic [2:0] curBuf;
    logic setupTok;
    logic discard;
    logic rxBad;
    logic ctlDirIn;
    logic zlp;
    logic [15:0] rdData;
    logic irq;
    logic dmaReq;
    logic oscEn;
    logic txValid;
    logic [7:0] txData;
    logic txEop;
    logic hsValid;
    logic hsAck;
  } ude_regs_s;

  ude_regs_s s;
  ude_regs_s n;

  // buffer that serves an endpoint in one direction
  function automatic logic [2:0] ude_buf_of(input logic [1:0] ep, input logic tx);
    case (ep)
      2'h0: ude_buf_of = tx ? ude_pkg::BUF_EP0TX : ude_pkg::BUF_EP0RX;
      2'h1: ude_buf_of = ude_pkg::BUF_EP1;
      2'h2: ude_buf_of = ude_pkg::BUF_EP2;
      default: ude_buf_of = ude_pkg::BUF_EP3;
    endcase
  endfunction : ude_buf_of

  // endpoints 1 and 2 follow their direction bit, 3 always transmits
  function automatic logic ude_ep_tx(input logic [1:0] ep, input logic [1:0] dir);
    ude_ep_tx = (ep == 2'h3) || (ep == 2'h1 && dir[0]) || (ep == 2'h2 && dir[1]);
  endfunction : ude_ep_tx

  // clamp a max packet size to 64 bytes on endpoints 1 and 2, 8 bytes on the others
  function automatic logic [6:0] ude_cap(input logic [2:0] idx, input logic [6:0] v);
    logic [6:0] lim;
    lim = (idx == ude_pkg::BUF_EP1 || idx == ude_pkg::BUF_EP2) ? ude_pkg::MAX_BULK
                                                               : ude_pkg::MAX_SMALL;
    ude_cap = (v > lim) ? lim : v;
  endfunction : ude_cap

  logic se0Now;
  logic jNow;
  logic rstHit;
  logic idleHit;
  logic fifoAcc;
  logic dmaAcc;
  logic [7:0] intStat;
  logic [1:0] fep;

  // line state from the second synchroniser stage only
  assign se0Now = !s.dpS[1] && !s.dmS[1];
  assign jNow = s.dpS[1] && !s.dmS[1];
  assign rstHit = se0Now && (s.se0Cnt == RST_M1);
  assign idleHit = jNow && (s.idleCnt == IDLE_M1);
  // fifo traffic is refused while the oscillator is stopped
  assign fifoAcc = (regWe || regRe) && !s.pwrDown
                   && (dmaAcknowledge || regAddr[5:2] == ude_pkg::PAGE_FIFO);
  assign dmaAcc = fifoAcc && dmaAcknowledge;
  assign fep = dmaAcknowledge ? 2'h1 : regAddr[1:0];

  // gated interrupt causes, transmit ones fire while the buffer is free
  always_comb begin
    intStat = '0;
    intStat[0] = s.intEn[0] && s.rxRdy[0];
    intStat[ude_pkg::BIT_EP0_TX] = s.intEn[ude_pkg::BIT_EP0_TX] && !s.txRdy[0];
    for (int i = 1; i < 3; i++) begin
      intStat[i] = s.intEn[i] && (s.dirTx[i-1] ? !s.txRdy[i] : s.rxRdy[i]);
    end
    intStat[ude_pkg::BIT_EP3_TX] = s.intEn[ude_pkg::BIT_EP3_TX] && !s.txRdy[3];
    intStat[ude_pkg::BIT_BUS_RESET] = s.intEn[ude_pkg::BIT_BUS_RESET] && s.busRst;
    intStat[ude_pkg::BIT_SUSPEND] = s.intEn[ude_pkg::BIT_SUSPEND] && s.susp;
  end

  // whole next-state computation
  always_comb begin
    logic [2:0] b;
    logic [2:0] fb;
    logic [6:0] len;
    logic ok;
    b = s.curBuf;
    fb = ude_buf_of(fep, regWe);
    len = '0;
    ok = 1'b0;
    n = s;
    n.hsValid = 1'b0;
    n.rdData = '0;
    n.dpS = {s.dpS[0], usbDp};
    n.dmS = {s.dmS[0], usbDm};

    // bus reset: saturating SE0 counter; hardware set beats software clear
    n.se0Cnt = se0Now ? ((s.se0Cnt == RST_M1) ? s.se0Cnt : s.se0Cnt + 10'h001) : '0;
    if (regWe && regAddr == ude_pkg::OFF_DEV_STATE && regWdata[ude_pkg::BIT_BUS_RESET]) begin
      n.busRst = 1'b0;
    end
    if (rstHit) begin
      n.busRst = 1'b1;
    end

    // suspend on long idle, left again on the SE0-then-J that ends resume
    n.idleCnt = jNow ? ((s.idleCnt == IDLE_M1) ? s.idleCnt : s.idleCnt + 20'h00001) : '0;
    if (idleHit) begin
      n.susp = 1'b1;
    end
    if (s.susp && se0Now) begin
      n.sawSe0 = 1'b1;
    end
    if (s.susp && s.sawSe0 && jNow) begin
      n.susp = 1'b0;
      n.sawSe0 = 1'b0;
    end

    // register writes
    if (regWe) begin
      case (regAddr)
        ude_pkg::OFF_SYS_CTRL: begin
          if (regWdata[7:0] == ude_pkg::PWRDN_KEY) begin
            n.pwrDown = 1'b1;
          end
        end
        ude_pkg::OFF_PKT_READY: begin
          for (int i = 0; i < 3; i++) begin
            if (regWdata[i] && s.rxRdy[i]) begin
              n.rxRdy[i] = 1'b0;
              n.wp[ude_buf_of(2'(i), 1'b0)] = '0;
              n.rp[ude_buf_of(2'(i), 1'b0)] = '0;
            end
          end
          n.txRdy = s.txRdy | regWdata[7:4];
        end
        ude_pkg::OFF_INT_ENABLE: n.intEn = regWdata[7:0];
        ude_pkg::OFF_DIR_CTRL: n.dirTx = regWdata[1:0];
        ude_pkg::OFF_DMA_CTRL: n.dmaCtl = regWdata[2:0];
        default: begin
          if (regAddr[5:3] == ude_pkg::PAGE_MAXPKT && regAddr[2:0] <= ude_pkg::BUF_EP3) begin
            n.maxPkt[regAddr[2:0]] = ude_cap(regAddr[2:0], regWdata[6:0]);
          end
        end
      endcase
    end

    // register reads, data valid in the following cycle only
    if (regRe) begin
      case (regAddr)
        ude_pkg::OFF_DEV_STATE: begin
          n.rdData[ude_pkg::BIT_BUS_RESET] = s.busRst;
          n.rdData[ude_pkg::BIT_SUSPEND] = s.susp;
        end
        ude_pkg::OFF_SYS_CTRL: n.rdData[7:0] = s.pwrDown ? ude_pkg::PWRDN_KEY : 8'h00;
        ude_pkg::OFF_PKT_READY: n.rdData[7:0] = {s.txRdy, 1'b0, s.rxRdy};
        ude_pkg::OFF_INT_ENABLE: n.rdData[7:0] = s.intEn;
        ude_pkg::OFF_INT_STATUS: n.rdData[7:0] = intStat;
        ude_pkg::OFF_RX_CNT0: n.rdData[6:0] = s.rxCnt[0];
        ude_pkg::OFF_RX_CNT1: n.rdData[6:0] = s.rxCnt[1];
        ude_pkg::OFF_RX_CNT2: n.rdData[6:0] = s.rxCnt[2];
        ude_pkg::OFF_DIR_CTRL: n.rdData[1:0] = s.dirTx;
        ude_pkg::OFF_DMA_CTRL: n.rdData[2:0] = s.dmaCtl;
        default: begin
          if (regAddr[5:3] == ude_pkg::PAGE_SETUP) begin
            n.rdData[7:0] = s.setup[regAddr[2:0]];
          end else if (regAddr[5:3] == ude_pkg::PAGE_MAXPKT && regAddr[2:0] <= ude_pkg::BUF_EP3) begin
            n.rdData[6:0] = s.maxPkt[regAddr[2:0]];
          end
        end
      endcase
    end

    // fifo ports: wide DMA moves low byte then high byte
    if (fifoAcc) begin
      for (int k = 0; k < 2; k++) begin
        if (k == 0 || (dmaAcknowledge && s.dmaCtl[ude_pkg::DMA_WIDE])) begin
          if (regWe && n.wp[fb] < s.maxPkt[fb]) begin
            n.mem[fb][n.wp[fb][5:0]] = regWdata[8*k +: 8];
            n.wp[fb] = n.wp[fb] + 7'h01;
          end
          if (regRe && fep != 2'h3 && n.rp[fb] < s.rxCnt[fep]) begin
            n.rdData[8*k +: 8] = s.mem[fb][n.rp[fb][5:0]];
            n.rp[fb] = n.rp[fb] + 7'h01;
          end
        end
      end
      // a DMA-filled full packet is handed to the link without firmware
      if (dmaAcc && regWe && s.dirTx[0] && n.wp[ude_pkg::BUF_EP1] == s.maxPkt[ude_pkg::BUF_EP1]) begin
        n.txRdy[1] = 1'b1;
      end
    end

    // packet engine towards the serial interface engine
    unique case (s.st)
      ude_pkg::ST_IDLE: begin
        if (uTokValid && !s.pwrDown) begin
          n.curEp = uTokEp;
          n.rxBad = 1'b0;
          n.setupTok = 1'b0;
          if (uTokPid == ude_pkg::TOK_SETUP) begin
            n.setupTok = 1'b1;
            n.setCnt = '0;
            n.discard = 1'b0;
            n.st = ude_pkg::ST_RX;
          end else if (uTokPid == ude_pkg::TOK_OUT) begin
            ok = uTokEp != 2'h3 && !ude_ep_tx(uTokEp, s.dirTx) && !s.rxRdy[uTokEp];
            n.curBuf = ude_buf_of(uTokEp, 1'b0);
            n.discard = !ok;
            if (ok) begin
              n.wp[n.curBuf] = '0;
            end
            n.st = ude_pkg::ST_RX;
          end else begin
            n.curBuf = ude_buf_of(uTokEp, 1'b1);
            ok = s.txRdy[uTokEp] && (uTokEp == 2'h0 || ude_ep_tx(uTokEp, s.dirTx));
            n.rp[n.curBuf] = '0;
            if (ok) begin
              n.zlp = 1'b0;
              n.st = ude_pkg::ST_TX;
            end else if (uTokEp == 2'h0 && !s.ctlDirIn) begin
              n.zlp = 1'b1;
              n.st = ude_pkg::ST_TX;
            end else begin
              n.hsValid = 1'b1; // not ready: NAK
              n.hsAck = 1'b0;
            end
          end
        end
      end
      ude_pkg::ST_RX: begin
        if (uRxValid) begin
          if (s.setupTok) begin
            if (s.setCnt < ude_pkg::SETUP_LEN) begin
              n.setup[s.setCnt[2:0]] = uRxData;
              n.setCnt = s.setCnt + 4'h1;
            end else begin
              n.rxBad = 1'b1;
            end
          end else if (!s.discard) begin
            if (s.wp[b] < s.maxPkt[b]) begin
              n.mem[b][s.wp[b][5:0]] = uRxData;
              n.wp[b] = s.wp[b] + 7'h01;
            end else begin
              n.rxBad = 1'b1;
            end
          end
        end
        if (uRxErr) begin
          n.rxBad = 1'b1;
        end
        // EOP ends the packet; the marker itself is never stored
        if (uRxEop) begin
          n.st = ude_pkg::ST_IDLE;
          if (!(s.rxBad || uRxErr)) begin
            if (s.setupTok) begin
              n.hsValid = s.setCnt == ude_pkg::SETUP_LEN;
              n.hsAck = 1'b1;
              n.ctlDirIn = s.setup[0][7];
            end else if (s.discard) begin
              n.hsValid = 1'b1;
              n.hsAck = 1'b0;
            end else begin
              n.hsValid = 1'b1;
              n.hsAck = 1'b1;
              if (!(s.curEp == 2'h0 && s.wp[b] == '0 && s.ctlDirIn)) begin
                n.rxCnt[s.curEp] = s.wp[b];
                n.rxRdy[s.curEp] = 1'b1;
              end
            end
          end
        end
      end
      ude_pkg::ST_TX: begin
        len = s.zlp ? '0 : ((s.wp[b] < s.maxPkt[b]) ? s.wp[b] : s.maxPkt[b]);
        if (s.txValid && s.txEop && uTxReady) begin
          n.txValid = 1'b0;
          n.txEop = 1'b0;
          n.st = ude_pkg::ST_ACKW;
        end else if (!s.txValid || uTxReady) begin
          n.txValid = 1'b1;
          if (s.rp[b] < len) begin
            n.txData = s.mem[b][s.rp[b][5:0]];
            n.rp[b] = s.rp[b] + 7'h01;
          end else begin
            n.txEop = 1'b1;
          end
        end
      end
      ude_pkg::ST_ACKW: begin
        if (uHostAck) begin
          if (!s.zlp) begin
            n.txRdy[s.curEp] = 1'b0;
            n.wp[b] = '0;
          end
          n.rp[b] = '0;
          n.st = ude_pkg::ST_IDLE;
        end else if (uTokValid) begin
          n.rp[b] = '0; // no ACK came: keep the packet for a retry
          n.st = ude_pkg::ST_IDLE;
        end
      end
    endcase

    // a bus reset aborts whatever transaction is running
    if (rstHit) begin
      n.st = ude_pkg::ST_IDLE;
      n.txValid = 1'b0;
      n.txEop = 1'b0;
    end

    // endpoint 1 DMA request; single mode leaves a gap after each unit
    ok = n.dirTx[0] ? (!n.txRdy[1] && n.wp[ude_pkg::BUF_EP1] < n.maxPkt[ude_pkg::BUF_EP1])
                    : (n.rxRdy[1] && n.rp[ude_pkg::BUF_EP1] < n.rxCnt[1]);
    n.dmaReq = n.dmaCtl[ude_pkg::DMA_EN] && !n.pwrDown && ok
               && !(s.dmaCtl[ude_pkg::DMA_SINGLE] && dmaAcc);
    n.irq = |intStat;
    n.oscEn = !n.pwrDown;
  end

  // one register for all state; reset also restarts the oscillator
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s <= '0;
      s.st <= ude_pkg::ST_IDLE;
      s.maxPkt <= ude_pkg::MAXPKT_RST;
      s.oscEn <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign regRdata = s.rdData;
  assign dmaRequest = s.dmaReq;
  assign intRequestOut = s.irq;
  assign oscEnable = s.oscEn;
  assign uTxValid = s.txValid;
  assign uTxData = s.txData;
  assign uTxEop = s.txEop;
  assign uHsValid = s.hsValid;
  assign uHsAck = s.hsAck;

  property p_bus_reset;
    @(posedge ref_clk) disable iff (sys_rst) se0Now [*8] ##0 (s.se0Cnt == RST_M1) |=> s.busRst;
  endproperty
  a_bus_reset: assert property (p_bus_reset) else $error("bus reset not flagged");
  property p_reset_clear;
    @(posedge ref_clk) disable iff (sys_rst)
      (regWe && regAddr == ude_pkg::OFF_DEV_STATE && regWdata[ude_pkg::BIT_BUS_RESET]
       && !rstHit) |=> !s.busRst;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("bus reset not cleared");
  property p_resume;
    @(posedge ref_clk) disable iff (sys_rst) (s.susp && s.sawSe0 && jNow) |=> !s.susp;
  endproperty
  a_resume: assert property (p_resume) else $error("suspend not ended on resume");
  property p_pwrdn;
    @(posedge ref_clk) disable iff (sys_rst)
      (regWe && regAddr == ude_pkg::OFF_SYS_CTRL && regWdata[7:0] == ude_pkg::PWRDN_KEY)
      |=> !oscEnable;
  endproperty
  a_pwrdn: assert property (p_pwrdn) else $error("oscillator still running");
  property p_pd_fifo;
    @(posedge ref_clk) disable iff (sys_rst) (s.pwrDown && regRe) |=> $stable(s.rp);
  endproperty
  a_pd_fifo: assert property (p_pd_fifo) else $error("fifo read in power-down");
  property p_tx_done;
    @(posedge ref_clk) disable iff (sys_rst)
      (s.st == ude_pkg::ST_ACKW && uHostAck && !s.zlp) |=> !s.txRdy[$past(s.curEp)];
  endproperty
  a_tx_done: assert property (p_tx_done) else $error("tx ready not cleared on ACK");
  property p_single;
    @(posedge ref_clk) disable iff (sys_rst)
      (s.dmaCtl[ude_pkg::DMA_SINGLE] && dmaAcc && !$past(rstHit)) |=> !dmaRequest;
  endproperty
  a_single: assert property (p_single) else $error("single DMA request not dropped");
  property p_int_gate;
    @(posedge ref_clk) disable iff (sys_rst) (s.intEn == 8'h00) |=> !intRequestOut;
  endproperty
  a_int_gate: assert property (p_int_gate) else $error("interrupt while disabled");
endmodule : ude_endpoint_engine

// File: logic/ude_pkg.sv
/*
  Shared constants for the USB device endpoint engine: register offsets,
  bit positions, reset values, buffer numbering, line timing and states.
  Assumes a 125 MHz core clock and an 8-bit register map on a 6-bit address.
*/
package ude_pkg;
  // core clock
  localparam real CLK_PERIOD_NS = 8.0;
  // line timing: bus reset after 2.5 us of SE0, suspend after 3 ms of idle
  localparam real BUS_RESET_SE0_US = 2.5;
  localparam real SUSPEND_IDLE_MS = 3.0;
  localparam int BUS_RESET_CYC = int'($ceil(BUS_RESET_SE0_US * 1000.0 / CLK_PERIOD_NS));
  localparam int SUSPEND_IDLE_CYC = int'($ceil(SUSPEND_IDLE_MS * 1.0e6 / CLK_PERIOD_NS));

  // register offsets (byte addresses on the plain register port)
  localparam logic [5:0] OFF_DEV_STATE = 6'h00;
  localparam logic [5:0] OFF_SYS_CTRL = 6'h01;
  localparam logic [5:0] OFF_PKT_READY = 6'h02;
  localparam logic [5:0] OFF_INT_ENABLE = 6'h03;
  localparam logic [5:0] OFF_INT_STATUS = 6'h04;
  localparam logic [5:0] OFF_RX_CNT0 = 6'h05;
  localparam logic [5:0] OFF_RX_CNT1 = 6'h06;
  localparam logic [5:0] OFF_RX_CNT2 = 6'h07;
  localparam logic [5:0] OFF_DIR_CTRL = 6'h08;
  localparam logic [5:0] OFF_DMA_CTRL = 6'h09;
  localparam logic [2:0] PAGE_SETUP = 3'h2;   // 0x10..0x17 setup bytes
  localparam logic [2:0] PAGE_MAXPKT = 3'h3;  // 0x18..0x1c max packet sizes
  localparam logic [3:0] PAGE_FIFO = 4'h8;    // 0x20..0x23 endpoint fifo ports

  // bit positions
  localparam int BIT_BUS_RESET = 5;
  localparam int BIT_SUSPEND = 6;
  localparam int BIT_EP0_TX = 4;
  localparam int BIT_EP3_TX = 7;
  localparam int DMA_EN = 0;
  localparam int DMA_SINGLE = 1;
  localparam int DMA_WIDE = 2;
  localparam logic [7:0] PWRDN_KEY = 8'ha0;

  // buffer numbering, shared with the max packet size index
  localparam logic [2:0] BUF_EP0RX = 3'h0;
  localparam logic [2:0] BUF_EP0TX = 3'h1;
  localparam logic [2:0] BUF_EP1 = 3'h2;
  localparam logic [2:0] BUF_EP2 = 3'h3;
  localparam logic [2:0] BUF_EP3 = 3'h4;
  localparam logic [6:0] MAX_SMALL = 7'h08;
  localparam logic [6:0] MAX_BULK = 7'h40;
  localparam logic [3:0] SETUP_LEN = 4'h8;
  localparam logic [4:0][6:0] MAXPKT_RST = {MAX_SMALL, MAX_BULK, MAX_BULK, MAX_SMALL, MAX_SMALL};

  // token kinds from the serial engine
  localparam logic [1:0] TOK_OUT = 2'h0;
  localparam logic [1:0] TOK_IN = 2'h1;
  localparam logic [1:0] TOK_SETUP = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RX = 4'b0010,
    ST_TX = 4'b0100,
    ST_ACKW = 4'b1000
  } ude_state_e;
endpackage : ude_pkg

// File: tb/ude_host_model.sv
/*
  Host-side serial engine model: issues tokens and data bytes, takes the
  device's packet bytes with random stalls, acks good packets.
  Assumes the engine's link ports on ref_clk, changed right after an edge.
*/
`timescale 1ns/10ps
module ude_host_model (
  input wire logic ref_clk,
  output logic uTokValid,
  output logic [1:0] uTokPid,
  output logic [1:0] uTokEp,
  output logic uRxValid,
  output logic [7:0] uRxData,
  output logic uRxEop,
  output logic uRxErr,
  output logic uTxReady,
  output logic uHostAck,
  input wire logic uTxValid,
  input wire logic [7:0] uTxData,
  input wire logic uTxEop,
  input wire logic uHsValid,
  input wire logic uHsAck
);
  logic [7:0] txQ[$];
  logic hsSeen = 1'b0;
  logic hsAck = 1'b0;
  logic eop = 1'b0;
  // idle link; error line never used since no scenario corrupts packets
  initial begin
    {uTokValid, uTokPid, uTokEp, uRxValid, uRxData, uRxEop, uRxErr, uHostAck} = '0;
    uTxReady = 1'b1;
  end
  // token cycle
  task automatic tok(input logic [1:0] pid, input logic [1:0] ep);
    @(posedge ref_clk);
    {uTokValid, uTokPid, uTokEp} <= {1'b1, pid, ep};
  endtask : tok
  // token, bytes, end of packet, then watch for the handshake
  task automatic pkt(input logic [1:0] pid, input logic [1:0] ep, input logic [7:0] b[$]);
    hsSeen = 1'b0;
    tok(pid, ep);
    foreach (b[i]) begin
      @(posedge ref_clk);
      {uTokValid, uTokPid, uRxValid, uRxData} <= {1'b0, ~pid, 1'b1, b[i]};
    end
    @(posedge ref_clk);
    {uTokValid, uRxValid, uRxData, uRxEop} <= {1'b0, 1'b0, ~uRxData, 1'b1};
    @(posedge ref_clk);
    uRxEop <= 1'b0;
    // handshake stands one cycle: look at mid-cycle, never on the launching edge
    repeat (8) begin
      @(negedge ref_clk);
      if (uHsValid) {hsSeen, hsAck} = {1'b1, uHsAck};
    end
  endtask : pkt
  // in token; collect bytes until the end beat, stalling at random
  task automatic inp(input logic [1:0] ep);
    logic done;
    done = 1'b0;
    txQ = {};
    tok(ude_pkg::TOK_IN, ep);
    // beat is judged on the values the engine samples at the coming edge
    for (int i = 0; i < 300 && !done; i++) begin
      @(negedge ref_clk);
      if (uTxValid && uTxReady && uTxEop) done = 1'b1;
      else if (uTxValid && uTxReady) txQ.push_back(uTxData);
      @(posedge ref_clk);
      {uTokValid, uTokPid, uTxReady} <= {1'b0, ~uTokPid, 1'($urandom)};
    end
    eop = done;
    uHostAck <= done;
    @(posedge ref_clk);
    {uHostAck, uTxReady} <= 2'b01;
  endtask : inp
endmodule : ude_host_model

// File: tb/tb.sv
/*
  Self-checking bench for the endpoint engine: register port master, line
  levels, host model on the link side, expectations kept in queues.
  Assumes a 125 MHz clock and a short suspend count for simulation.
*/
`timescale 1ns/10ps
module tb;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic usbDp = 1'b1;
  logic usbDm = 1'b0;
  logic [5:0] regAddr = '0;
  logic [15:0] regWdata = '0;
  logic regWe = 1'b0, regRe = 1'b0, dmaAcknowledge = 1'b0;
  logic [15:0] regRdata;
  logic dmaRequest, intRequestOut, oscEnable, uTokValid, uRxValid, uRxEop, uRxErr;
  logic uTxReady, uHostAck, uTxValid, uTxEop, uHsValid, uHsAck;
  logic [1:0] uTokPid, uTokEp;
  logic [7:0] uRxData, uTxData;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  ude_endpoint_engine #(.IdleCyc(50)) uut (.ref_clk, .sys_rst, .usbDp, .usbDm, .regAddr,
    .regWdata, .regWe, .regRe, .regRdata, .dmaAcknowledge, .dmaRequest, .intRequestOut,
    .oscEnable, .uTokValid, .uTokPid, .uTokEp, .uRxValid, .uRxData, .uRxEop, .uRxErr,
    .uTxReady, .uHostAck, .uTxValid, .uTxData, .uTxEop, .uHsValid, .uHsAck);
  ude_host_model host (.ref_clk, .uTokValid, .uTokPid, .uTokEp, .uRxValid, .uRxData,
    .uRxEop, .uRxErr, .uTxReady, .uHostAck, .uTxValid, .uTxData, .uTxEop, .uHsValid,
    .uHsAck);
  // clock
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one-cycle strobes, raised right after an edge
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    {regWe, regAddr, regWdata} <= {1'b1, a, d};
    @(posedge ref_clk);
    regWe <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic dk, output logic [15:0] d);
    @(posedge ref_clk);
    {regRe, regAddr, dmaAcknowledge} <= {1'b1, a, dk};
    @(posedge ref_clk);
    {regRe, dmaAcknowledge} <= 2'b00;
    #1 d = regRdata;
  endtask : rd
  task automatic rm(input logic [5:0] a, input logic [15:0] m, input logic [15:0] e);
    logic [15:0] d;
    rd(a, 1'b0, d);
    chk(d & m, e);
  endtask : rm
  // hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      print_verdict();
    end
  end
  // main sequence
  initial begin
    logic [7:0] b[$];
    logic [15:0] d;
    int n;
    int mp[5] = '{8, 8, 64, 64, 8};
    logic [15:0] dm[2] = '{16'h0001, 16'h0007};
    void'($urandom(30654));
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    foreach (mp[i]) rm(6'(6'h18 + i), 16'hffff, 16'(mp[i]));
    wr(6'h19, 16'h00ff);
    wr(6'h1a, 16'h00ff);
    rm(6'h19, 16'hffff, 16'h0008);
    rm(6'h1a, 16'hffff, 16'h0040);
    // setup then a no-data status stage
    repeat (8) b.push_back(8'($urandom));
    b[0][7] = 1'b0;
    host.pkt(ude_pkg::TOK_SETUP, 2'h0, b);
    chk({host.hsSeen, host.hsAck}, 2'b11);
    foreach (b[i]) rm(6'(6'h10 + i), 16'hffff, {8'h00, b[i]});
    host.inp(2'h0);
    chk({host.eop, 15'(host.txQ.size())}, 16'h8000);
    // endpoint 1 receive, random length, only its interrupt enabled
    wr(6'h03, 16'h0002);
    n = 1 + $urandom % 64;
    b = {};
    repeat (n) b.push_back(8'($urandom));
    host.pkt(ude_pkg::TOK_OUT, 2'h1, b);
    chk({host.hsSeen, host.hsAck}, 2'b11);
    rm(6'h06, 16'hffff, 16'(n));
    chk(intRequestOut, 1'b1);
    wr(6'h03, 16'h00ff);
    rm(6'h04, 16'h0082, 16'h0082);
    wr(6'h03, 16'h0000);
    rm(6'h04, 16'hffff, 16'h0000);
    chk(intRequestOut, 1'b0);
    wr(6'h03, 16'h00ff);
    foreach (b[i]) rm(6'h21, 16'hffff, {8'h00, b[i]});
    wr(6'h02, 16'h0002);
    rm(6'h02, 16'h0002, 16'h0000);
    // endpoint 2 short packet, then a zero-length one
    wr(6'h08, 16'h0002);
    n = 1 + $urandom % 63;
    b = {};
    repeat (n) begin
      b.push_back(8'($urandom));
      wr(6'h22, {8'h00, b[$]});
    end
    for (int k = 0; k < 2; k++) begin
      wr(6'h02, 16'h0040);
      host.inp(2'h2);
      chk({host.eop, 15'(host.txQ.size())}, {1'b1, 15'(k ? 0 : n)});
      if (k == 0) foreach (b[i]) chk(host.txQ[i], b[i]);
      rm(6'h02, 16'h0040, 16'h0000);
      rm(6'h04, 16'h0004, 16'h0004);
    end
    // dma on endpoint 1: demand byte mode, single word mode
    foreach (dm[k]) begin
      wr(6'h09, dm[k]);
      b = {};
      repeat (4) b.push_back(8'($urandom));
      host.pkt(ude_pkg::TOK_OUT, 2'h1, b);
      for (int i = 0; i < 4; i += 1 + dm[k][2]) begin
        @(posedge ref_clk);
        #1 chk(dmaRequest, 1'b1);
        rd(6'h21, 1'b1, d);
        chk(d, dm[k][2] ? {b[i+1], b[i]} : {8'h00, b[i]});
        if (dm[k][1]) chk(dmaRequest, 1'b0);
      end
      @(posedge ref_clk);
      #1 chk(dmaRequest, 1'b0);
      wr(6'h02, 16'h0002);
    end
    // line states: suspend, bus reset, resume
    rm(6'h00, 16'h0040, 16'h0040);
    @(posedge ref_clk);
    {usbDp, usbDm} <= 2'b00;
    repeat (250) @(posedge ref_clk);
    rm(6'h00, 16'h0020, 16'h0000);
    repeat (80) @(posedge ref_clk);
    rm(6'h00, 16'h0020, 16'h0020);
    // let J pass the synchroniser so the held SE0 no longer re-flags reset
    @(posedge ref_clk);
    {usbDp, usbDm} <= 2'b10;
    repeat (3) @(posedge ref_clk);
    wr(6'h00, 16'h0020);
    rm(6'h00, 16'h0060, 16'h0000);
    // power-down and the way out
    wr(6'h01, 16'h00a0);
    @(posedge ref_clk);
    #1 chk(oscEnable, 1'b0);
    rm(6'h01, 16'h00ff, 16'h00a0);
    host.pkt(ude_pkg::TOK_OUT, 2'h2, b);
    chk(host.hsSeen, 1'b0);
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    #1 chk(oscEnable, 1'b1);
    print_verdict();
  end
endmodule : tb
